// ### common/bojx_pkg.sv
// Purpose: constants for the single-bit and jump executor
// Assumes: one clock state per ref_clk cycle
// Notes: opcode fields follow the 8-bit instruction layout
package bojx_pkg;
	localparam logic [7:0] OP_BIT_PREFIX = 8'hCB;
	localparam logic [7:0] OP_IDX1_PREFIX = 8'hDD;
	localparam logic [7:0] OP_IDX2_PREFIX = 8'hFD;
	localparam logic [7:0] OP_ABS_JUMP = 8'hC3;
	localparam logic [7:0] OP_REL_JUMP = 8'h18;
	localparam logic [1:0] GRP_TEST = 2'h1;
	localparam logic [1:0] GRP_ZERO = 2'h2;
	localparam logic [1:0] GRP_ONE = 2'h3;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [1:0] JCC_TOP = 2'h3;
	localparam logic [2:0] JCC_LOW = 3'h2;
	localparam logic [1:0] JRC_TOP = 2'h0;
	localparam logic [2:0] JRC_LOW = 3'h0;
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam int FLAG_C = 0;
	localparam int FLAG_N = 1;
	localparam int FLAG_PV = 2;
	localparam int FLAG_H = 4;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 7;
	localparam logic [4:0] T_BIT_REG = 5'h08;
	localparam logic [4:0] T_BIT_PTR = 5'h0C;
	localparam logic [4:0] T_BIT_IDX = 5'h14;
	localparam logic [4:0] T_SET_REG = 5'h08;
	localparam logic [4:0] T_SET_PTR = 5'h0F;
	localparam logic [4:0] T_SET_IDX = 5'h17;
	localparam logic [4:0] T_ABS = 5'h0A;
	localparam logic [4:0] T_REL_NO = 5'h07;
	localparam logic [4:0] T_REL_YES = 5'h0C;
	localparam logic [4:0] T_ILLEGAL = 5'h04;
	localparam logic [2:0] M_BIT_REG = 3'h2;
	localparam logic [2:0] M_BIT_PTR = 3'h3;
	localparam logic [2:0] M_BIT_IDX = 3'h5;
	localparam logic [2:0] M_SET_PTR = 3'h4;
	localparam logic [2:0] M_SET_IDX = 3'h6;
	localparam logic [2:0] M_JUMP = 3'h3;
	localparam logic [2:0] M_REL_NO = 3'h2;
	localparam logic [2:0] M_ONE = 3'h1;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [4:0] T_STEP = 5'h01;
	typedef enum logic [2:0] {
		BOJX_IDLE = 3'b000,
		BOJX_BYTE2 = 3'b001,
		BOJX_BYTE3 = 3'b010,
		BOJX_BYTE4 = 3'b011,
		BOJX_WAIT = 3'b100
	} bojx_state_e;
endpackage : bojx_pkg

// ### core/bojx_cond.sv
// Purpose: condition field evaluation
// Assumes: flags in the usual bit positions
// Notes: combinational
`timescale 1ns/1ps
module bojx_cond import bojx_pkg::*; (
	input wire logic [2:0] condition_field,
	input wire logic [7:0] flags,
	output logic cond_true
);
	always_comb begin
		case (condition_field)
			3'b000: cond_true = !flags[FLAG_Z];
			3'b001: cond_true = flags[FLAG_Z];
			3'b010: cond_true = !flags[FLAG_C];
			3'b011: cond_true = flags[FLAG_C];
			3'b100: cond_true = !flags[FLAG_PV];
			3'b101: cond_true = flags[FLAG_PV];
			3'b110: cond_true = !flags[FLAG_S];
			default: cond_true = flags[FLAG_S];
		endcase
	end
endmodule : bojx_cond

// ### core/bojx_exec.sv
// Purpose: decode and execute single-bit ops and jumps
// Assumes: one instruction byte offered per fetch handshake
// Notes: operand reads and writes go through a simple data port
`timescale 1ns/1ps
module bojx_exec import bojx_pkg::*; (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic byte_ready,
	input wire logic [7:0] operand_in,
	output logic [7:0] operand_out,
	output logic operand_we,
	output logic [2:0] operand_sel,
	output logic [1:0] operand_space,
	output logic [7:0] displacement,
	output logic [15:0] pc,
	output logic [7:0] flags,
	input wire logic flags_load,
	input wire logic [7:0] flags_in,
	output logic done,
	output logic [2:0] m_cycles,
	output logic [4:0] t_states,
	output logic illegal
);
	bojx_state_e state_reg, state_next;
	logic [7:0] op1_reg;
	logic [7:0] lo_reg;
	logic [7:0] disp_reg;
	logic [1:0] space_reg;
	logic [4:0] wait_reg;
	logic [15:0] pc_reg;
	logic [7:0] flags_reg;
	logic [7:0] opout_reg;
	logic we_reg;
	logic [2:0] sel_reg;
	logic done_reg;
	logic [2:0] m_reg;
	logic [4:0] t_reg;
	logic ill_reg;
	logic cond_true;
	logic take;
	logic [4:0] t_set;
	logic [2:0] m_set;

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction : bit_mask

	bojx_cond u_cond (
		.condition_field(op1_reg[5:3]),
		.flags(flags_reg),
		.cond_true(cond_true)
	);

	assign byte_ready = (state_reg != BOJX_WAIT);
	assign take = byte_valid && byte_ready;
	assign pc = pc_reg;
	assign flags = flags_reg;
	assign operand_out = opout_reg;
	assign operand_we = we_reg;
	assign operand_sel = sel_reg;
	assign operand_space = space_reg;
	assign displacement = disp_reg;
	assign done = done_reg;
	assign m_cycles = m_reg;
	assign t_states = t_reg;
	assign illegal = ill_reg;

	// force-one and force-zero share one timing table
	always_comb begin
		case (space_reg)
			2'h0: begin
				t_set = (byte_data[2:0] == REG_MEM) ? T_SET_PTR : T_SET_REG;
				m_set = (byte_data[2:0] == REG_MEM) ? M_SET_PTR : M_BIT_REG;
			end
			default: begin
				t_set = T_SET_IDX;
				m_set = M_SET_IDX;
			end
		endcase
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			BOJX_IDLE: if (take) begin
				if (byte_data == OP_IDX1_PREFIX || byte_data == OP_IDX2_PREFIX ||
					byte_data == OP_BIT_PREFIX || byte_data == OP_ABS_JUMP ||
					byte_data == OP_REL_JUMP ||
					(byte_data[7:6] == JCC_TOP && byte_data[2:0] == JCC_LOW) ||
					(byte_data[7:5] == 3'b001 && byte_data[2:0] == JRC_LOW))
					state_next = BOJX_BYTE2;
			end
			BOJX_BYTE2: if (take) begin
				if (op1_reg == OP_BIT_PREFIX && space_reg == 2'h0)
					state_next = BOJX_WAIT;
				else if (op1_reg == OP_BIT_PREFIX)
					state_next = BOJX_BYTE3;
				else if (op1_reg[7:6] == JRC_TOP)
					state_next = BOJX_WAIT;
				else
					state_next = BOJX_BYTE3;
			end
			BOJX_BYTE3: if (take)
				state_next = (op1_reg == OP_BIT_PREFIX) ? BOJX_BYTE4 : BOJX_WAIT;
			BOJX_BYTE4: if (take)
				state_next = BOJX_WAIT;
			BOJX_WAIT: if (wait_reg <= T_STEP)
				state_next = BOJX_IDLE;
			default: state_next = BOJX_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			state_reg <= BOJX_IDLE;
		else
			state_reg <= state_next;
	end

	// instruction capture, program counter and timing
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			op1_reg <= 8'h00;
			lo_reg <= 8'h00;
			disp_reg <= 8'h00;
			space_reg <= 2'h0;
			wait_reg <= 5'h00;
			pc_reg <= PC_RESET;
			m_reg <= 3'h0;
			t_reg <= 5'h00;
			done_reg <= 1'b0;
			ill_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			ill_reg <= 1'b0;
			if (state_reg == BOJX_WAIT)
				wait_reg <= wait_reg - T_STEP;
			if (state_reg == BOJX_WAIT && wait_reg <= T_STEP)
				done_reg <= 1'b1;
			if (take) begin
				pc_reg <= pc_reg + PC_STEP;
				wait_reg <= wait_reg - T_STEP;
				case (state_reg)
					BOJX_IDLE: begin
						op1_reg <= byte_data;
						space_reg <= 2'h0;
						if (byte_data == OP_IDX1_PREFIX || byte_data == OP_IDX2_PREFIX) begin
							op1_reg <= OP_BIT_PREFIX;
							space_reg <= (byte_data == OP_IDX1_PREFIX) ? 2'h1 : 2'h2;
						end
						if (state_next == BOJX_IDLE) begin
							ill_reg <= 1'b1;
							done_reg <= 1'b1;
							m_reg <= M_ONE;
							t_reg <= T_ILLEGAL;
						end
					end
					BOJX_BYTE2: begin
						lo_reg <= byte_data;
						disp_reg <= byte_data;
						if (op1_reg == OP_BIT_PREFIX && space_reg == 2'h0) begin
							case (byte_data[7:6])
								GRP_TEST: begin
									t_reg <= (byte_data[2:0] == REG_MEM) ? T_BIT_PTR : T_BIT_REG;
									m_reg <= (byte_data[2:0] == REG_MEM) ? M_BIT_PTR : M_BIT_REG;
									wait_reg <= ((byte_data[2:0] == REG_MEM) ? T_BIT_PTR : T_BIT_REG)
										- T_STEP - T_STEP;
								end
								default: begin
									t_reg <= t_set;
									m_reg <= m_set;
									wait_reg <= t_set - T_STEP - T_STEP;
								end
							endcase
							if (byte_data[7:6] == 2'h0)
								ill_reg <= 1'b1;
							if (wait_reg <= T_STEP && t_set <= T_STEP)
								done_reg <= 1'b1;
						end else if (op1_reg[7:6] == JRC_TOP) begin
							// pc is past the first byte only, so one step is added along with the displacement
							m_reg <= take_rel() ? M_JUMP : M_REL_NO;
							t_reg <= take_rel() ? T_REL_YES : T_REL_NO;
							wait_reg <= (take_rel() ? T_REL_YES : T_REL_NO) - T_STEP - T_STEP;
							if (take_rel())
								pc_reg <= pc_reg + PC_STEP + {{8{byte_data[7]}}, byte_data};
						end
					end
					BOJX_BYTE3: begin
						if (op1_reg == OP_BIT_PREFIX) begin
							disp_reg <= byte_data;
						end else if (op1_reg[7:6] == JCC_TOP) begin
							m_reg <= M_JUMP;
							t_reg <= T_ABS;
							wait_reg <= T_ABS - T_STEP - T_STEP - T_STEP;
							if (op1_reg == OP_ABS_JUMP || cond_true)
								pc_reg <= {byte_data, lo_reg};
						end
					end
					BOJX_BYTE4: begin
						m_reg <= (byte_data[7:6] == GRP_TEST) ? M_BIT_IDX : m_set;
						t_reg <= (byte_data[7:6] == GRP_TEST) ? T_BIT_IDX : t_set;
						wait_reg <= ((byte_data[7:6] == GRP_TEST) ? T_BIT_IDX : t_set)
							- T_STEP - T_STEP - T_STEP - T_STEP;
						if (byte_data[7:6] == 2'h0)
							ill_reg <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	function automatic logic take_rel();
		logic [2:0] c;
		c = op1_reg[5:3];
		case (c)
			3'b011: take_rel = 1'b1;
			3'b100: take_rel = !flags_reg[FLAG_Z];
			3'b101: take_rel = flags_reg[FLAG_Z];
			3'b110: take_rel = !flags_reg[FLAG_C];
			3'b111: take_rel = flags_reg[FLAG_C];
			default: take_rel = 1'b0;
		endcase
	endfunction : take_rel

	// operand update for the single-bit group
	logic bit_op_now;
	logic [7:0] bit_byte;
	assign bit_op_now = take && op1_reg == OP_BIT_PREFIX &&
		((state_reg == BOJX_BYTE2 && space_reg == 2'h0) || state_reg == BOJX_BYTE4);
	assign bit_byte = byte_data;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			opout_reg <= 8'h00;
			we_reg <= 1'b0;
			sel_reg <= 3'h0;
			flags_reg <= FLAGS_RESET;
		end else begin
			we_reg <= 1'b0;
			if (flags_load)
				flags_reg <= flags_in;
			if (bit_op_now) begin
				sel_reg <= bit_byte[2:0];
				case (bit_byte[7:6])
					GRP_TEST: begin
						flags_reg[FLAG_Z] <= !(|(operand_in & bit_mask(bit_byte[5:3])));
						flags_reg[FLAG_H] <= 1'b1;
						flags_reg[FLAG_N] <= 1'b0;
					end
					GRP_ONE: begin
						opout_reg <= operand_in | bit_mask(bit_byte[5:3]);
						we_reg <= 1'b1;
					end
					GRP_ZERO: begin
						opout_reg <= operand_in & ~bit_mask(bit_byte[5:3]);
						we_reg <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end
endmodule : bojx_exec

// ### testbench/bojx_exec_checker.sv
// Purpose: port checks for bojx_exec
// Assumes: single clock domain
// Notes: bound below
`timescale 1ns/1ps
module bojx_exec_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] operand_in,
	input wire logic [7:0] operand_out,
	input wire logic operand_we,
	input wire logic [7:0] flags,
	input wire logic done,
	input wire logic [2:0] m_cycles,
	input wire logic [4:0] t_states
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_done_pulse;
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too wide");
	property p_we_pulse;
		operand_we |=> !operand_we;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write too wide");
	property p_idx_set;
		done && t_states == 5'h17 |-> m_cycles == 3'h6;
	endproperty
	a_idx_set: assert property (p_idx_set) else $error("indexed write cycles");
	property p_idx_test;
		done && t_states == 5'h14 |-> m_cycles == 3'h5;
	endproperty
	a_idx_test: assert property (p_idx_test) else $error("indexed test cycles");
	property p_rel_short;
		done && m_cycles == 3'h2 |-> t_states inside {5'h07, 5'h08};
	endproperty
	a_rel_short: assert property (p_rel_short) else $error("short states");
	property p_one_bit;
		operand_we |-> $countones(operand_out ^ $past(operand_in)) <= 1;
	endproperty
	a_one_bit: assert property (p_one_bit) else $error("several bits changed");
	property p_flags_keep;
		operand_we |-> $stable(flags);
	endproperty
	a_flags_keep: assert property (p_flags_keep) else $error("flags moved");
	property p_jump_time;
		done && t_states == 5'h0A |-> m_cycles == 3'h3;
	endproperty
	a_jump_time: assert property (p_jump_time) else $error("jump cycles");
endmodule : bojx_exec_checker
bind bojx_exec bojx_exec_checker bojx_exec_checker_i (.ref_clk, .rst_n, .operand_in,
	.operand_out, .operand_we, .flags, .done, .m_cycles, .t_states);

// ### testbench/bojx_exec_test.sv
// Purpose: self-checking bench for bojx_exec
// Assumes: stalling program memory model
// Notes: random operands and flags, fixed seed
`timescale 1ns/1ps
module bojx_exec_test import bojx_pkg::*;;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic flags_load = 1'b0;
	logic stall = 1'b0;
	logic [7:0] flags_in = 8'h00;
	logic [7:0] operand_in = 8'h00;
	logic byte_valid, byte_ready, operand_we, done, we_seen, tk;
	logic [7:0] byte_data, operand_out, flags, out_cap, fl, op, e, opnd;
	logic [15:0] pc, exp_pc, nn;
	logic [2:0] m_cycles, bsel, r;
	logic [4:0] t_states;
	logic [1:0] grp, form;
	logic [7:0] prog[$];
	int failures = 0;
	int tests_run = 0;
	int seed = 32'h006D2DE2;
	int cyc = 0;
	int n;
	always #5 ref_clk = ~ref_clk;
	bojx_exec bojx_exec_i (.ref_clk, .rst_n, .byte_valid, .byte_data, .byte_ready, .operand_in,
		.operand_out, .operand_we, .operand_sel(), .operand_space(), .displacement(), .pc,
		.flags, .flags_load, .flags_in, .done, .m_cycles, .t_states, .illegal());
	bojx_pmem bojx_pmem_i (.ref_clk, .rst_n, .stall, .byte_ready, .byte_valid, .byte_data);
	task close_out;
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : close_out
	task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp16
	task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
		cmp16({8'h00, got}, {8'h00, exp});
	endtask : cmp8
	function automatic logic cond_ok(input logic [2:0] c, input logic [7:0] f);
		logic v;
		case (c[2:1])
			2'h0: v = f[FLAG_Z];
			2'h1: v = f[FLAG_C];
			2'h2: v = f[FLAG_PV];
			default: v = f[FLAG_S];
		endcase
		return v == c[0];
	endfunction : cond_ok
	function automatic logic [15:0] exp_mt(input logic [1:0] g, input logic [1:0] f);
		if (f == 2'h0) return 16'h0208;
		if (g == GRP_TEST) return f == 2'h1 ? 16'h030C : 16'h0514;
		return f == 2'h1 ? 16'h040F : 16'h0617;
	endfunction : exp_mt
	// loads flags, then hands the bytes in prog to memory and waits for done
	task automatic run(input logic [7:0] f, input logic [7:0] o);
		@(posedge ref_clk);
		flags_load <= 1'b1;
		flags_in <= f;
		operand_in <= o;
		@(posedge ref_clk);
		flags_load <= 1'b0;
		we_seen = 1'b0;
		bojx_pmem_i.q = prog;
		n = 0;
		#1;
		while (done !== 1'b1 && n < 100) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n == 100) failures++;
	endtask : run
	always @(posedge ref_clk) begin
		cyc++;
		if (operand_we === 1'b1) begin
			we_seen = 1'b1;
			out_cap = operand_out;
		end
		stall <= 1'($random(seed));
		if (cyc == 20000) begin
			failures++;
			close_out;
		end
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		exp_pc = 16'h0000;
		for (int k = 0; k < 24; k++) begin
			grp = 2'(k % 3 + 1);
			form = 2'((k / 3) % 4);
			bsel = 3'(k);
			r = 3'($random(seed));
			if (r == REG_MEM) r = 3'h7;
			op = {grp, bsel, form == 2'h0 ? r : REG_MEM};
			e = 8'($random(seed));
			opnd = 8'($random(seed));
			fl = 8'($random(seed));
			if (form[1]) prog = '{form[0] ? OP_IDX2_PREFIX : OP_IDX1_PREFIX, OP_BIT_PREFIX, e, op};
			else prog = '{OP_BIT_PREFIX, op};
			run(fl, opnd);
			exp_pc = exp_pc + (form[1] ? 16'h0004 : 16'h0002);
			cmp16(pc, exp_pc);
			cmp16({5'h0, m_cycles, 3'h0, t_states}, exp_mt(grp, form));
			if (grp == GRP_TEST) cmp8(flags & 8'h53, {1'b0, ~opnd[bsel], 2'h1, 3'h0, fl[0]});
			else begin
				cmp8(flags, fl);
				cmp8({7'h00, we_seen}, 8'h01);
				cmp8(out_cap, grp == GRP_ONE ? opnd | (8'h01 << bsel) : opnd & ~(8'h01 << bsel));
			end
		end
		for (int c = 0; c < 33; c++) begin
			fl = {8{c[3]}} ^ (8'($random(seed)) & 8'h2A);
			nn = 16'($random(seed));
			e = c == 20 ? 8'h80 : c == 21 ? 8'h7F : nn[7:0];
			if (c < 17) begin
				tk = c == 16 || cond_ok(3'(c), fl);
				prog = '{c == 16 ? OP_ABS_JUMP : {JCC_TOP, 3'(c), JCC_LOW}, nn[7:0], nn[15:8]};
				run(fl, 8'h00);
				exp_pc = tk ? nn : exp_pc + 16'h0003;
				cmp16({5'h0, m_cycles, 3'h0, t_states}, 16'h030A);
			end else begin
				tk = c == 32 || cond_ok({1'b0, 2'(c)}, fl);
				prog = '{c == 32 ? OP_REL_JUMP : {JRC_TOP, 1'b1, 2'(c), JRC_LOW}, e};
				run(fl, 8'h00);
				exp_pc = exp_pc + 16'h0002 + (tk ? {{8{e[7]}}, e} : 16'h0000);
				cmp16({5'h0, m_cycles, 3'h0, t_states}, tk ? 16'h030C : 16'h0207);
			end
			cmp16(pc, exp_pc);
			cmp8(flags, fl);
		end
		close_out;
	end
endmodule : bojx_exec_test

// ### testbench/bojx_pmem.sv
// Purpose: program memory model
// Assumes: bench loads q while idle
// Notes: data toggles while nothing is offered
`timescale 1ns/1ps
module bojx_pmem (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic byte_ready,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	logic [7:0] q[$];
	logic go;
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_valid <= 1'b0;
			byte_data <= 8'h5A;
		end else begin
			if (byte_valid && byte_ready) void'(q.pop_front());
			go = (byte_valid && !byte_ready) || (q.size() != 0 && !stall);
			byte_valid <= go;
			byte_data <= go ? q[0] : ~byte_data;
		end
	end
endmodule : bojx_pmem
